// ### design/vector_map_pkg.sv
package vector_map_pkg;

    // Source counts and widths
    localparam int NUM_MASKABLE = 28;
    localparam int NUM_LEVELS = 8;
    localparam int LEVEL_W = 3;
    localparam int SOURCE_W = 5;
    localparam int CODE_W = 16;
    localparam int ADDR_W = 32;
    localparam int OPERAND_W = 4;

    // Fixed sources, lowest index taken first
    localparam int NUM_FIXED = 6;
    localparam int FIXED_W = 3;
    localparam logic [2:0] FIX_RESET = 3'h0;
    localparam logic [2:0] FIX_ILLEGAL = 3'h1;
    localparam logic [2:0] FIX_TRAP_A = 3'h2;
    localparam logic [2:0] FIX_TRAP_B = 3'h3;
    localparam logic [2:0] FIX_NMI = 3'h4;
    localparam logic [2:0] FIX_WDT = 3'h5;

    // Exception codes and handler addresses
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [15:0] CODE_NMI = 16'h0010;
    localparam logic [15:0] CODE_WDT = 16'h0020;
    localparam logic [15:0] CODE_TRAP_A = 16'h0040;
    localparam logic [15:0] CODE_TRAP_B = 16'h0050;
    localparam logic [15:0] CODE_ILLEGAL = 16'h0060;
    localparam logic [15:0] CODE_MASKABLE_BASE = 16'h0080;
    localparam logic [15:0] CODE_STEP = 16'h0010;
    localparam logic [31:0] ADDR_RESET = 32'h00000000;
    localparam logic [31:0] ADDR_NMI = 32'h00000010;
    localparam logic [31:0] ADDR_WDT = 32'h00000020;
    localparam logic [31:0] ADDR_TRAP_A = 32'h00000040;
    localparam logic [31:0] ADDR_TRAP_B = 32'h00000050;
    localparam logic [31:0] ADDR_ILLEGAL = 32'h00000060;

    // Default priority positions of the maskable sources
    localparam int PRIO_VOLT_FALL = 0;
    localparam int PRIO_VOLT_RISE = 1;
    localparam int PRIO_PIN_BASE = 2;
    localparam int NUM_PINS = 8;
    localparam int PRIO_TIMER_B_OVF = 10;
    localparam int PRIO_TIMER_B_CH = 11;
    localparam int NUM_TIMER_B_CH = 4;
    localparam int PRIO_TIMER_A_BASE = 15;
    localparam int TIMER_A_STRIDE = 3;
    localparam int NUM_TIMER_A = 5;

    // Request to service start, in system clock cycles
    localparam int MIN_LATENCY_CYCLES = 5;
    localparam int AGE_W = 3;

    typedef enum logic [2:0] {
        KIND_RESET,
        KIND_NMI,
        KIND_WDT,
        KIND_TRAP_A,
        KIND_TRAP_B,
        KIND_ILLEGAL,
        KIND_MASKABLE
    } vector_kind_type;

endpackage

// ### design/source_slot.sv
`timescale 1ns/1ps

module source_slot #(
    parameter int AGE_READY = 3,
    parameter int AGE_W = 3
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic request,
    input wire logic clear,
    output logic pending,
    output logic ready
);

    localparam logic [AGE_W-1:0] AGE_LIMIT = AGE_W'(AGE_READY);

    logic [AGE_W-1:0] age;
    logic [AGE_W-1:0] next_age;
    logic next_pending;

    if (AGE_READY < 0 || AGE_READY >= (1 << AGE_W)) begin : g_check
        $error("source_slot: AGE_READY does not fit AGE_W");
    end

    always_comb begin
        next_pending = pending;
        next_age = age;
        if (pending && age != AGE_LIMIT) begin
            next_age = age + 1'h1;
        end
        if (clear) begin
            next_pending = 1'h0;
        end
        // New request wins over a clear and restarts the age
        if (request) begin
            next_pending = 1'h1;
            next_age = '0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= 1'h0;
            age <= '0;
        end else begin
            pending <= next_pending;
            age <= next_age;
        end
    end

    assign ready = pending && (age == AGE_LIMIT);

endmodule

// ### design/exception_vector_priority_map.sv
`timescale 1ns/1ps

// Summary of operation
// - internal reset vectors code 0000, address 0
// - NMI pin valid edge: code/address 0010
// - second watchdog overflow: non-maskable, code 0020
// - trap group A gives 004n, handler 0040
// - trap group B gives 005n, handler 0050
// - illegal opcode or debug trap: 0060
// - voltage fall: priority 0, code 0080
// - voltage rise: priority 1, code 0090
// - maskable handler equals code; 0080 plus 16*priority
// - pins 0-7: priorities 2-9, codes 00A0-0110
// - enhanced timer: overflow 10, channels 11-14
// - timers A0-A3: overflow, ch0, ch1 from 15; A4 overflow only, at 27
// - service starts five or more cycles after request
// - eight programmable levels, masks, nested by level
module exception_vector_priority_map #(
    parameter int MIN_LATENCY = vector_map_pkg::MIN_LATENCY_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reset_request,
    input wire logic nmi_pin,
    input wire logic nmi_rising_edge,
    input wire logic watchdog_overflow_request,
    input wire logic trap_group_a,
    input wire logic trap_group_b,
    input wire logic [3:0] trap_operand,
    input wire logic illegal_opcode_trap,
    input wire logic debug_trap,
    input wire logic voltage_fall_request,
    input wire logic voltage_rise_request,
    input wire logic [7:0] pin_request,
    input wire logic timer_b0_overflow_request,
    input wire logic [3:0] timer_b0_channel_request,
    input wire logic [4:0] timer_a_overflow_request,
    input wire logic [4:0] timer_a_channel0_request,
    input wire logic [4:0] timer_a_channel1_request,
    input wire logic [27:0] irq_mask,
    input wire logic [83:0] irq_level,
    input wire logic cpu_ready,
    input wire logic cpu_return,
    output logic vector_valid,
    output logic [15:0] exception_code,
    output logic [31:0] handler_address,
    output logic restore_next_pc,
    output vector_map_pkg::vector_kind_type vector_kind,
    output logic [4:0] vector_source,
    output logic [2:0] vector_level,
    output logic [7:0] in_service_levels,
    output logic nmi_in_service,
    output logic [27:0] maskable_pending
);

    localparam int NM = vector_map_pkg::NUM_MASKABLE;
    localparam int NF = vector_map_pkg::NUM_FIXED;
    localparam int LW = vector_map_pkg::LEVEL_W;

    if (MIN_LATENCY < 2 || MIN_LATENCY > 9) begin : g_check
        $error("MIN_LATENCY must lie between 2 and 9");
    end

    // Pin synchronisers and edge detection
    logic [1:0] nmi_sync;
    logic nmi_prev;
    logic [7:0] pin_sync0;
    logic [7:0] pin_sync1;
    logic [7:0] pin_prev;
    logic nmi_edge;
    logic [7:0] pin_edge;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_sync <= '0;
            nmi_prev <= 1'h0;
            pin_sync0 <= '0;
            pin_sync1 <= '0;
            pin_prev <= '0;
        end else begin
            nmi_sync <= {nmi_sync[0], nmi_pin};
            nmi_prev <= nmi_sync[1];
            pin_sync0 <= pin_request;
            pin_sync1 <= pin_sync0;
            pin_prev <= pin_sync1;
        end
    end

    // Valid edge of the NMI pin is selectable
    assign nmi_edge = nmi_rising_edge ? (nmi_sync[1] && !nmi_prev)
                                      : (!nmi_sync[1] && nmi_prev);
    assign pin_edge = pin_sync1 & ~pin_prev;

    // Request vectors in default priority order
    logic [NF-1:0] fixed_req;
    logic [NF-1:0] fixed_ready;
    logic [NF-1:0] fixed_clear;
    logic [NM-1:0] mreq;
    logic [NM-1:0] m_ready;
    logic [NM-1:0] m_clear;

    always_comb begin
        fixed_req = '0;
        fixed_req[vector_map_pkg::FIX_RESET] = reset_request;
        fixed_req[vector_map_pkg::FIX_ILLEGAL] =
            illegal_opcode_trap || debug_trap;
        fixed_req[vector_map_pkg::FIX_TRAP_A] = trap_group_a;
        fixed_req[vector_map_pkg::FIX_TRAP_B] = trap_group_b;
        fixed_req[vector_map_pkg::FIX_NMI] = nmi_edge;
        fixed_req[vector_map_pkg::FIX_WDT] =
            watchdog_overflow_request;
        mreq = '0;
        mreq[vector_map_pkg::PRIO_VOLT_FALL] = voltage_fall_request;
        mreq[vector_map_pkg::PRIO_VOLT_RISE] = voltage_rise_request;
        for (int i = 0; i < vector_map_pkg::NUM_PINS; i++) begin
            mreq[vector_map_pkg::PRIO_PIN_BASE + i] = pin_edge[i];
        end
        mreq[vector_map_pkg::PRIO_TIMER_B_OVF] =
            timer_b0_overflow_request;
        for (int i = 0; i < vector_map_pkg::NUM_TIMER_B_CH; i++) begin
            mreq[vector_map_pkg::PRIO_TIMER_B_CH + i] =
                timer_b0_channel_request[i];
        end
        for (int t = 0; t < vector_map_pkg::NUM_TIMER_A; t++) begin
            mreq[vector_map_pkg::PRIO_TIMER_A_BASE
                 + vector_map_pkg::TIMER_A_STRIDE * t] =
                timer_a_overflow_request[t];
            // Last timer's channels lie beyond the mapped sources
            if (t < vector_map_pkg::NUM_TIMER_A - 1) begin
                mreq[vector_map_pkg::PRIO_TIMER_A_BASE
                     + vector_map_pkg::TIMER_A_STRIDE * t + 1] =
                    timer_a_channel0_request[t];
                mreq[vector_map_pkg::PRIO_TIMER_A_BASE
                     + vector_map_pkg::TIMER_A_STRIDE * t + 2] =
                    timer_a_channel1_request[t];
            end
        end
    end

    // Each source waits out the latency before it may be taken
    for (genvar i = 0; i < NF; i++) begin : g_fixed
        source_slot #(
            .AGE_READY(MIN_LATENCY - 2),
            .AGE_W(vector_map_pkg::AGE_W)
        ) u_slot (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .request(fixed_req[i]),
            .clear(fixed_clear[i]),
            .pending(),
            .ready(fixed_ready[i])
        );
    end

    for (genvar i = 0; i < NM; i++) begin : g_mask
        source_slot #(
            .AGE_READY(MIN_LATENCY - 2),
            .AGE_W(vector_map_pkg::AGE_W)
        ) u_slot (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .request(mreq[i]),
            .clear(m_clear[i]),
            .pending(maskable_pending[i]),
            .ready(m_ready[i])
        );
    end

    // Trap operands held while their trap waits
    logic [3:0] trap_a_operand;
    logic [3:0] trap_b_operand;
    logic [3:0] next_trap_a_operand;
    logic [3:0] next_trap_b_operand;

    // Selection
    logic fix_hit;
    logic [2:0] fix_idx;
    logic m_hit;
    logic [4:0] m_idx;
    logic [LW-1:0] m_lvl;
    logic [LW:0] cur_level;
    logic [LW-1:0] lvl_i;
    logic take;

    always_comb begin
        fix_hit = 1'h0;
        fix_idx = '0;
        // Non-maskables are blind to mask and level
        for (int i = NF - 1; i >= 0; i--) begin
            if (fixed_ready[i] && !(3'(i) == vector_map_pkg::FIX_NMI
                                    && nmi_in_service)) begin
                fix_hit = 1'h1;
                fix_idx = 3'(i);
            end
        end
        cur_level = (LW + 1)'(vector_map_pkg::NUM_LEVELS);
        for (int i = vector_map_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
            if (in_service_levels[i]) begin
                cur_level = (LW + 1)'(i);
            end
        end
        m_hit = 1'h0;
        m_idx = '0;
        m_lvl = '1;
        lvl_i = '0;
        for (int i = 0; i < NM; i++) begin
            lvl_i = irq_level[i*LW +: LW];
            // Strict compare keeps the smaller default priority
            if (m_ready[i] && !irq_mask[i] && !nmi_in_service
                && {1'h0, lvl_i} < cur_level
                && (!m_hit || lvl_i < m_lvl)) begin
                m_hit = 1'h1;
                m_idx = 5'(i);
                m_lvl = lvl_i;
            end
        end
        take = cpu_ready && (fix_hit || m_hit);
        fixed_clear = '0;
        m_clear = '0;
        if (take && fix_hit) begin
            fixed_clear[fix_idx] = 1'h1;
        end
        if (take && !fix_hit) begin
            m_clear[m_idx] = 1'h1;
        end
    end

    // Vector output and nesting state
    logic next_vector_valid;
    logic [15:0] next_exception_code;
    logic [31:0] next_handler_address;
    logic next_restore_next_pc;
    vector_map_pkg::vector_kind_type next_vector_kind;
    logic [4:0] next_vector_source;
    logic [2:0] next_vector_level;
    logic [7:0] next_in_service_levels;
    logic next_nmi_in_service;

    always_comb begin
        next_trap_a_operand = trap_group_a ? trap_operand : trap_a_operand;
        next_trap_b_operand = trap_group_b ? trap_operand : trap_b_operand;
        next_vector_valid = take;
        next_exception_code = exception_code;
        next_handler_address = handler_address;
        next_restore_next_pc = restore_next_pc;
        next_vector_kind = vector_kind;
        next_vector_source = vector_source;
        next_vector_level = vector_level;
        next_in_service_levels = in_service_levels;
        next_nmi_in_service = nmi_in_service;
        if (cpu_return) begin
            if (nmi_in_service) begin
                next_nmi_in_service = 1'h0;
            end else begin
                next_in_service_levels = in_service_levels
                    & ~(in_service_levels & (~in_service_levels + 8'h01));
            end
        end
        if (take) begin
            next_restore_next_pc = 1'h1;
            next_vector_source = '0;
            next_vector_level = '0;
            if (fix_hit) begin
                unique case (fix_idx)
                    vector_map_pkg::FIX_RESET: begin
                        next_exception_code = vector_map_pkg::CODE_RESET;
                        next_handler_address = vector_map_pkg::ADDR_RESET;
                        next_vector_kind = vector_map_pkg::KIND_RESET;
                        next_restore_next_pc = 1'h0;
                        next_in_service_levels = '0;
                        next_nmi_in_service = 1'h0;
                    end
                    vector_map_pkg::FIX_ILLEGAL: begin
                        next_exception_code = vector_map_pkg::CODE_ILLEGAL;
                        next_handler_address =
                            vector_map_pkg::ADDR_ILLEGAL;
                        next_vector_kind = vector_map_pkg::KIND_ILLEGAL;
                    end
                    vector_map_pkg::FIX_TRAP_A: begin
                        next_exception_code = vector_map_pkg::CODE_TRAP_A
                            | {12'h000, trap_a_operand};
                        next_handler_address = vector_map_pkg::ADDR_TRAP_A;
                        next_vector_kind = vector_map_pkg::KIND_TRAP_A;
                    end
                    vector_map_pkg::FIX_TRAP_B: begin
                        next_exception_code = vector_map_pkg::CODE_TRAP_B
                            | {12'h000, trap_b_operand};
                        next_handler_address = vector_map_pkg::ADDR_TRAP_B;
                        next_vector_kind = vector_map_pkg::KIND_TRAP_B;
                    end
                    vector_map_pkg::FIX_NMI: begin
                        next_exception_code = vector_map_pkg::CODE_NMI;
                        next_handler_address = vector_map_pkg::ADDR_NMI;
                        next_vector_kind = vector_map_pkg::KIND_NMI;
                        next_nmi_in_service = 1'h1;
                    end
                    vector_map_pkg::FIX_WDT: begin
                        next_exception_code = vector_map_pkg::CODE_WDT;
                        next_handler_address = vector_map_pkg::ADDR_WDT;
                        next_vector_kind = vector_map_pkg::KIND_WDT;
                        next_nmi_in_service = 1'h1;
                    end
                    default: begin
                        next_vector_kind = vector_kind;
                    end
                endcase
            end else begin
                next_exception_code = vector_map_pkg::CODE_MASKABLE_BASE
                    + 16'(m_idx) * vector_map_pkg::CODE_STEP;
                next_handler_address = {16'h0000,
                    vector_map_pkg::CODE_MASKABLE_BASE
                    + 16'(m_idx) * vector_map_pkg::CODE_STEP};
                next_vector_kind = vector_map_pkg::KIND_MASKABLE;
                next_vector_source = m_idx;
                next_vector_level = m_lvl;
                next_in_service_levels[m_lvl] = 1'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            trap_a_operand <= '0;
            trap_b_operand <= '0;
            vector_valid <= 1'h0;
            exception_code <= '0;
            handler_address <= '0;
            restore_next_pc <= 1'h0;
            vector_kind <= vector_map_pkg::KIND_RESET;
            vector_source <= '0;
            vector_level <= '0;
            in_service_levels <= '0;
            nmi_in_service <= 1'h0;
        end else begin
            trap_a_operand <= next_trap_a_operand;
            trap_b_operand <= next_trap_b_operand;
            vector_valid <= next_vector_valid;
            exception_code <= next_exception_code;
            handler_address <= next_handler_address;
            restore_next_pc <= next_restore_next_pc;
            vector_kind <= next_vector_kind;
            vector_source <= next_vector_source;
            vector_level <= next_vector_level;
            in_service_levels <= next_in_service_levels;
            nmi_in_service <= next_nmi_in_service;
        end
    end

    // Checks
    logic [27:0] past_mask;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            past_mask <= '0;
        end else begin
            past_mask <= irq_mask;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence fall_fresh_s;
        voltage_fall_request && !maskable_pending[0];
    endsequence

    sequence no_fall_vector_s;
        !(vector_valid && vector_source == 5'h00
          && vector_kind == vector_map_pkg::KIND_MASKABLE);
    endsequence

    latency_floor_a: assert property (
        fall_fresh_s |=> no_fall_vector_s [*4])
        else $error("voltage fall vector taken too early");
    reset_vector_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_RESET
        |-> exception_code == 16'h0000 && handler_address == 32'h0
            && !restore_next_pc && in_service_levels == 8'h00)
        else $error("reset vector wrong");
    nmi_vector_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_NMI
        |-> exception_code == 16'h0010 && handler_address == 32'h10
            && nmi_in_service)
        else $error("NMI vector wrong");
    wdt_vector_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_WDT
        |-> exception_code == 16'h0020 && handler_address == 32'h20)
        else $error("watchdog vector wrong");
    trap_a_vector_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_TRAP_A
        |-> exception_code[15:4] == 12'h004 && handler_address == 32'h40)
        else $error("trap group A vector wrong");
    trap_b_vector_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_TRAP_B
        |-> exception_code[15:4] == 12'h005 && handler_address == 32'h50)
        else $error("trap group B vector wrong");
    illegal_vector_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_ILLEGAL
        |-> exception_code == 16'h0060 && handler_address == 32'h60)
        else $error("illegal opcode vector wrong");
    maskable_map_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_MASKABLE
        |-> exception_code == 16'h0080 + {7'h00, vector_source, 4'h0}
            && handler_address == {16'h0000, exception_code})
        else $error("maskable code or handler wrong");
    mask_honoured_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_MASKABLE
        |-> !past_mask[vector_source])
        else $error("masked source was taken");
    nest_level_a: assert property (
        vector_valid && vector_kind == vector_map_pkg::KIND_MASKABLE
        |-> in_service_levels[vector_level]
            && vector_level
               == 3'($past(irq_level) >> (3 * vector_source)))
        else $error("level not marked in service");

endmodule

// ### bench/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic vector_valid,
    input wire vector_map_pkg::vector_kind_type vector_kind,
    output logic cpu_ready,
    output logic cpu_return
);
    logic [1:0] tick;
    logic [2:0] busy;
    // Slow core accepts a vector one cycle in four
    assign cpu_ready = !slow || tick == 2'h0;
    assign cpu_return = busy == 3'h1;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tick <= 2'h0;
            busy <= 3'h0;
        end else begin
            tick <= tick + 2'h1;
            if (vector_valid && vector_kind inside {vector_map_pkg::KIND_NMI,
                vector_map_pkg::KIND_WDT, vector_map_pkg::KIND_MASKABLE})
                busy <= 3'h6;
            else if (busy != 3'h0)
                busy <= busy - 3'h1;
        end
    end
endmodule

// ### bench/tb_exception_vector_priority_map.sv
`timescale 1ns/1ps
module tb_exception_vector_priority_map;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic slow = 1'b0;
    logic nmi_rise = 1'b1;
    logic [34:0] stim = 35'h0;
    logic [3:0] op = 4'h0;
    logic [27:0] mask = 28'h0;
    logic [83:0] lvl = 84'h0;
    logic [15:0] rnd = 16'hC1C2;
    logic ready, ret, vv, rnpc, nis;
    logic [15:0] code;
    logic [31:0] addr;
    vector_map_pkg::vector_kind_type kind;
    logic [4:0] vsrc;
    logic [2:0] vlvl;
    logic [7:0] isl;
    logic [27:0] pend;
    int n_errors = 0;
    int tests_run = 0;

    initial forever #2.5 mclk = ~mclk;

    exception_vector_priority_map DUT (
        .mclk(mclk), .sys_rst(sys_rst), .reset_request(stim[28]),
        .nmi_pin(stim[29]), .nmi_rising_edge(nmi_rise),
        .watchdog_overflow_request(stim[30]), .trap_group_a(stim[31]),
        .trap_group_b(stim[32]), .trap_operand(op),
        .illegal_opcode_trap(stim[33]), .debug_trap(stim[34]),
        .voltage_fall_request(stim[0]), .voltage_rise_request(stim[1]),
        .pin_request(stim[9:2]), .timer_b0_overflow_request(stim[10]),
        .timer_b0_channel_request(stim[14:11]),
        .timer_a_overflow_request({stim[27], stim[24], stim[21], stim[18],
            stim[15]}),
        .timer_a_channel0_request({1'b0, stim[25], stim[22], stim[19],
            stim[16]}),
        .timer_a_channel1_request({1'b0, stim[26], stim[23], stim[20],
            stim[17]}),
        .irq_mask(mask), .irq_level(lvl), .cpu_ready(ready),
        .cpu_return(ret), .vector_valid(vv), .exception_code(code),
        .handler_address(addr), .restore_next_pc(rnpc), .vector_kind(kind),
        .vector_source(vsrc), .vector_level(vlvl), .in_service_levels(isl),
        .nmi_in_service(nis), .maskable_pending(pend)
    );
    cpu_core_model cpu (.mclk(mclk), .sys_rst(sys_rst), .slow(slow),
        .vector_valid(vv), .vector_kind(kind), .cpu_ready(ready),
        .cpu_return(ret));

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] mcode(int i);
        return 16'h0080 + 16'(i * 16);
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic drive(logic [34:0] v, int hold);
        @(posedge mclk);
        stim <= v;
        repeat (hold) @(posedge mclk);
        stim <= 35'h0;
    endtask
    task automatic wait_vec(output int lat);
        lat = 0;
        do begin
            @(negedge mclk);
            lat++;
        end while (vv !== 1'b1 && lat < 300);
        check("vector_valid", 1, vv);
    endtask
    // Let every handler return before the next case
    task automatic settle();
        for (int k = 0; k < 60 && (isl !== 8'h0 || nis !== 1'b0); k++)
            @(negedge mclk);
        @(posedge mclk);
    endtask
    task automatic mvec(int i, int lat);
        check("code", mcode(i), code);
        check("address", {16'h0, mcode(i)}, addr);
        check("kind", vector_map_pkg::KIND_MASKABLE, kind);
        check("source", i, vsrc);
        check("level", lvl[3*i+:3], vlvl);
        check("next_pc", 1, rnpc);
        check("latency", 1, lat >= 5);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        int lat;
        logic [15:0] ec;
        logic [15:0] base[7] = '{16'h0000, 16'h0010, 16'h0020, 16'h0040,
            16'h0050, 16'h0060, 16'h0060};
        vector_map_pkg::vector_kind_type kt[7] = '{vector_map_pkg::KIND_RESET,
            vector_map_pkg::KIND_NMI, vector_map_pkg::KIND_WDT,
            vector_map_pkg::KIND_TRAP_A, vector_map_pkg::KIND_TRAP_B,
            vector_map_pkg::KIND_ILLEGAL, vector_map_pkg::KIND_ILLEGAL};
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 28; i++) begin
            rnd = lfsr(rnd);
            slow <= rnd[0];
            lvl[3*i+:3] <= rnd[3:1];
            drive(35'h1 << i, (i >= 2 && i <= 9) ? 4 : 1);
            wait_vec(lat);
            // Four-cycle pin hold leaves the measured count one cycle short; add it back
            mvec(i, (i >= 2 && i <= 9) ? lat + 1 : lat);
            settle();
            $display("maskable source %0d done", i);
        end
        mask <= 28'hFFFFFFF;
        for (int r = 0; r < 3; r++) begin
            for (int f = 0; f < 7; f++) begin
                rnd = lfsr(rnd);
                op <= (r == 0) ? 4'h0 : (r == 1) ? 4'hF : rnd[3:0];
                // Last round takes the NMI on its falling edge
                nmi_rise <= (r != 2);
                drive(35'h1 << (28 + f), f == 1 ? 4 : 1);
                wait_vec(lat);
                ec = base[f] | ((f == 3 || f == 4) ? {12'h0, op} : 16'h0);
                check("code", ec, code);
                check("address", {16'h0, base[f]}, addr);
                check("kind", kt[f], kind);
                check("next_pc", f != 0, rnpc);
                settle();
                $display("fixed source %0d done", f);
            end
        end
        mask <= 28'h0000400;
        drive(35'h400, 1);
        lat = 0;
        repeat (30) begin
            @(negedge mclk);
            if (vv !== 1'b0) lat++;
        end
        check("masked_vector", 0, lat);
        check("pending", 1, pend[10]);
        @(posedge mclk);
        mask <= 28'h0;
        wait_vec(lat);
        mvec(10, 5);
        settle();
        $display("mask done");
        for (int t = 0; t < 2; t++) begin
            lvl[38:36] <= t ? 3'h5 : 3'h2;
            lvl[62:60] <= t ? 3'h1 : 3'h2;
            drive(35'h0101000, 1);
            wait_vec(lat);
            mvec(t ? 20 : 12, lat);
            wait_vec(lat);
            mvec(t ? 12 : 20, 5);
            settle();
            $display("priority case %0d done", t);
        end
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("BAD run_time expected finish seen timeout");
        wrap_up();
    end
endmodule
